// ===== adc_conversion_control.v
// Purpose: control wrapper for a 12-bit successive-approximation converter
// Assumes: APB slave, zero-wait answers, one clock ref_clk, sync reset
// Notes:   analog core returns one result bit per converter clock, MSB first
//
// overview of the data path:
// - apb slave with one wait-free access phase; answer is registered
// - control registers hold start, power, alignment, channel and clock code
// - divider makes a one-cycle tick per converter clock while converting
// - sequencer counts 16 ticks: 4 sampling ticks, then 12 result ticks
// - result bits arrive msb first and shift into a 12-bit register
// - both result bytes and the status flag load on the finishing tick
// - every analog side output is a flip-flop; converter_clk tracks the divider, converter_reset and sampling the sequencer, irq status, the rest copy fields
//
// limitations a user must know:
// - the undefined clock code behaves as the slowest divide
// - a start edge while powered off is dropped, not queued
// - writing start high mid-conversion aborts it and forces busy high
// - reading status clears it; a finish in the same cycle still sets it
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module adc_conversion_control (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        comparator_out,
   output reg         converter_clk,
   output reg         converter_reset,
   output reg         converter_power_on,
   output reg         sampling,
   output reg  [2:0]  channel_number_field,
   output reg         internal_ref_connect,
   output reg         bandgap_enable,
   output reg         external_ref_select,
   output reg  [7:0]  analog_channels,
   output reg  [7:0]  pull_high_disable,
   output reg  [7:0]  direction_override,
   output reg         irq
);
   reg  [7:0]  ctrl1_q;     // first control: start,-,power off,align,-,chan
   reg  [7:0]  ctrl2_q;     // second control: int ref,bandgap,-,ref,-,clk sel
   reg  [7:0]  pin_sel_q;
   reg  [7:0]  res_lo_q;
   reg  [7:0]  res_hi_q;
   reg         busy_q;
   reg         start_prev_q;
   reg         run_q;
   reg  [4:0]  cyc_q;
   reg  [11:0] sar_q;
   reg  [6:0]  div_q;
   reg         tick_q;
   reg         stat_q;
   reg         mask_q;
   wire        wr_acc;
   wire        rd_acc;
   wire        start_bit;
   wire        start_fall;
   wire        done;
   wire [11:0] sar_d;

   // note on the register map:
   // - registers sit in the low byte of a 32-bit word; status and mask are 1 bit wide
   // - upper read bits are always zero
   // - unmapped addresses answer with an error and change nothing
   // - read-only bits (busy) ignore writes; spare bits read zero

   // divide ratio minus one for a clock select code
   function [6:0] div_limit;
      input [2:0] code;
      begin
         case (code)
            3'h0:    div_limit = 7'h00;
            3'h1:    div_limit = 7'h01;
            3'h2:    div_limit = 7'h03;
            3'h3:    div_limit = 7'h07;
            3'h4:    div_limit = 7'h0f;
            3'h5:    div_limit = 7'h1f;
            default: div_limit = 7'h3f; // undefined code treated as /64
         endcase
      end
   endfunction

   // access strobes, start edge detect, finishing tick and shift value
   // start_prev_q resets low, the idle level of the start bit, so no
   // false falling edge follows reset
   assign wr_acc     = psel & penable & pwrite;
   assign rd_acc     = psel & penable & ~pwrite;
   assign start_bit  = ctrl1_q[`BIT_START];
   assign start_fall = start_prev_q & ~start_bit;
   assign done       = run_q & tick_q & (cyc_q == `TOTAL_CYCLES - 5'h01);
   assign sar_d      = {sar_q[10:0], comparator_out};

   // register writes
   // writes land at the access edge only; the setup edge just decodes
   // spare bits are stored as zero so reads show them cleared
   always @(posedge ref_clk) begin
      if (reset) begin
         ctrl1_q   <= `RST_CTRL_FIRST;
         ctrl2_q   <= `RST_CTRL_SECOND;
         pin_sel_q <= `RST_PIN_SELECT;
         mask_q    <= 1'b0;
      end else if (wr_acc) begin
         if (paddr == `OFS_CTRL_FIRST)
            ctrl1_q <= {pwdata[7], 1'b0, pwdata[5:4], 1'b0, pwdata[2:0]};
         else if (paddr == `OFS_CTRL_SECOND)
            ctrl2_q <= {pwdata[7:6], 1'b0, pwdata[4], 1'b0, pwdata[2:0]};
         else if (paddr == `OFS_PIN_SELECT)
            pin_sel_q <= pwdata[7:0];
         else if (paddr == `OFS_IRQ_MASK)
            mask_q <= pwdata[0];
      end
   end

   // converter clock divider, one-cycle tick per converter clock
   // held cleared outside a conversion so every run starts phase aligned
   // also cleared on the finishing tick: with the undivided code the
   // divider would otherwise emit a 17th tick on the same edge
   always @(posedge ref_clk) begin
      if (reset || start_bit || !run_q || done) begin
         div_q  <= 7'h00;
         tick_q <= 1'b0;
      end else if (div_q >= div_limit(ctrl2_q[2:0])) begin
         div_q  <= 7'h00;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 7'h01;
         tick_q <= 1'b0;
      end
   end

   // conversion sequencer
   // start high wins over everything: converter held, busy forced high
   // the falling start edge launches a run only when powered
   // ticks 0..3 sample, ticks 4..15 shift one result bit each
   // the last tick clears busy and loads both result bytes together
   always @(posedge ref_clk) begin
      if (reset) begin
         busy_q       <= 1'b1;
         start_prev_q <= 1'b0;
         run_q        <= 1'b0;
         cyc_q        <= 5'h00;
         sar_q        <= 12'h000;
         res_lo_q     <= 8'h00;
         res_hi_q     <= 8'h00;
      end else begin
         start_prev_q <= start_bit;
         if (start_bit) begin
            busy_q <= 1'b1;
            run_q  <= 1'b0;
            cyc_q  <= 5'h00;
         end else if (start_fall && !ctrl1_q[`BIT_POWER_OFF]) begin
            run_q <= 1'b1;
            cyc_q <= 5'h00;
            sar_q <= 12'h000;
         end else if (run_q && tick_q) begin
            cyc_q <= cyc_q + 5'h01;
            if (cyc_q >= `SAMPLE_CYCLES)
               sar_q <= sar_d;
            if (done) begin
               run_q  <= 1'b0;
               busy_q <= 1'b0;
               if (ctrl1_q[`BIT_ALIGN]) begin
                  res_hi_q <= {4'h0, sar_d[11:8]};
                  res_lo_q <= sar_d[7:0];
               end else begin
                  res_hi_q <= sar_d[11:4];
                  res_lo_q <= {sar_d[3:0], 4'h0};
               end
            end
         end
      end
   end

   // sticky end-of-conversion status, cleared by reading it; set wins
   always @(posedge ref_clk) begin
      if (reset)
         stat_q <= 1'b0;
      else if (done)
         stat_q <= 1'b1;
      else if (rd_acc && paddr == `OFS_IRQ_STATUS)
         stat_q <= 1'b0;
   end

   // apb read data and answer
   // the setup edge decodes and registers the answer, so pready, prdata
   // and pslverr stand exactly in the access cycle; zero wait states
   // a back-to-back setup after an access is answered the same way
   always @(posedge ref_clk) begin
      if (reset) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            if (paddr == `OFS_CTRL_FIRST)
               prdata[7:0] <= {ctrl1_q[7], busy_q, ctrl1_q[5:0]};
            else if (paddr == `OFS_CTRL_SECOND)
               prdata[7:0] <= ctrl2_q;
            else if (paddr == `OFS_PIN_SELECT)
               prdata[7:0] <= pin_sel_q;
            else if (paddr == `OFS_RESULT_LOW)
               prdata[7:0] <= res_lo_q;
            else if (paddr == `OFS_RESULT_HIGH)
               prdata[7:0] <= res_hi_q;
            else if (paddr == `OFS_IRQ_STATUS)
               prdata[0] <= stat_q;
            else if (paddr == `OFS_IRQ_MASK)
               prdata[0] <= mask_q;
            else
               pslverr <= 1'b1;
         end
      end
   end

   // analog side outputs, all registered
   // each output trails its register by one edge; the checker allows two
   // pin select drives routing, pull-high removal and direction override
   // alike, so one register bit owns all three functions of a pin
   // the interrupt level follows status and mask, with done folded in so
   // the request is not a cycle later than the status flag
   always @(posedge ref_clk) begin
      if (reset) begin
         converter_clk        <= 1'b0;
         converter_reset      <= 1'b1;
         converter_power_on   <= 1'b0;
         sampling             <= 1'b0;
         channel_number_field <= 3'h0;
         internal_ref_connect <= 1'b0;
         bandgap_enable       <= 1'b0;
         external_ref_select  <= 1'b0;
         analog_channels      <= 8'h00;
         pull_high_disable    <= 8'h00;
         direction_override   <= 8'h00;
         irq                  <= 1'b0;
      end else begin
         converter_clk        <= tick_q;
         converter_reset      <= start_bit | ~run_q;
         converter_power_on   <= ~ctrl1_q[`BIT_POWER_OFF];
         sampling             <= run_q & (cyc_q < `SAMPLE_CYCLES);
         channel_number_field <= ctrl1_q[2:0];
         internal_ref_connect <= ctrl2_q[`BIT_INT_REF];
         bandgap_enable       <= ctrl2_q[`BIT_BANDGAP_EN];
         external_ref_select  <= ctrl2_q[`BIT_REF_SEL];
         analog_channels      <= pin_sel_q;
         pull_high_disable    <= pin_sel_q;
         direction_override   <= pin_sel_q;
         irq                  <= (stat_q | done) & mask_q;
      end
   end
endmodule

// ===== adc_conversion_control_bench.sv
// Purpose: self-checking bench for the converter control
// Assumes: zero-wait APB slave, 50 MHz clock
// Notes:   divider timing measured by polling the busy flag
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module adc_conversion_control_bench;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        level = 1'b0;
   logic        err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] q;
   wire  [31:0] prdata;
   wire         pready, pslverr, comparator_out, irq, external_ref_select;
   wire         converter_reset, converter_power_on;
   wire         converter_clk, sampling, internal_ref_connect;
   wire         bandgap_enable;
   integer      nclk = 0;
   integer      nsamp = 0;
   wire  [2:0]  channel_number_field;
   wire  [7:0]  analog_channels, pull_high_disable, direction_override;
   integer      num_errors = 0;
   integer      checked = 0;
   integer      cyc = 0;
   // clock and cycle count
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;
   // converter clock pulses, total and while sampling
   always @(posedge ref_clk) begin
      nclk <= nclk + converter_clk;
      nsamp <= nsamp + (converter_clk & sampling);
   end
   adc_conversion_control uut (.ref_clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .comparator_out,
      .converter_clk, .converter_reset, .converter_power_on, .sampling,
      .channel_number_field, .internal_ref_connect, .bandgap_enable,
      .external_ref_select, .analog_channels, .pull_high_disable,
      .direction_override, .irq);
   analog_core_model core (.ref_clk, .converter_reset, .converter_power_on,
      .level, .comparator_out);
   task chk(input [31:0] got, input [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one APB transfer, held until pready
   task apb(input w, input [11:0] a, input [7:0] d, output [31:0] r);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task test_reset;
      apb(0, `OFS_CTRL_FIRST, 0, q);
      chk(q, 32'h60);
      apb(0, `OFS_PIN_SELECT, 0, q);
      chk(q, 32'hff);
      chk(converter_power_on, 0);
      apb(0, 12'h01c, 0, q);
      chk({q[30:0], err}, 1);
      $display("reset test done");
   endtask
   task test_pins;
      apb(1, `OFS_PIN_SELECT, 8'h5a, q);
      apb(1, `OFS_CTRL_SECOND, 8'hd0, q);
      apb(0, `OFS_PIN_SELECT, 0, q);
      chk(q, 32'h5a);
      chk({analog_channels, pull_high_disable}, 16'h5a5a);
      chk(direction_override, 8'h5a);
      chk(external_ref_select, 1);
      chk({internal_ref_connect, bandgap_enable}, 2'b11);
      $display("pin test done");
   endtask
   task test_conv;
      integer c, t0, k0, s0;
      logic [11:0] v;
      logic [7:0] b;
      for (c = 0; c < 7; c = c + 1) begin
         level = c[0];
         v = {12{c[0]}};
         b = {3'b000, c[1], 1'b0, ~c[2:0]};
         apb(1, `OFS_CTRL_SECOND, {5'h00, c[2:0]}, q);
         apb(1, `OFS_IRQ_MASK, {7'h00, c < 4}, q);
         apb(1, `OFS_CTRL_FIRST, b, q);
         repeat (20) @(posedge ref_clk);
         apb(1, `OFS_CTRL_FIRST, b | 8'h80, q);
         apb(0, `OFS_CTRL_FIRST, 0, q);
         chk({q[6], converter_reset}, 2'b11);
         k0 = nclk;
         s0 = nsamp;
         apb(1, `OFS_CTRL_FIRST, b, q);
         t0 = cyc;
         while (q[6] === 1'b1) apb(0, `OFS_CTRL_FIRST, 0, q);
         chk(nclk - k0, 16);
         chk(nsamp - s0, 4);
         chk(cyc - t0 >= 16 << c && cyc - t0 <= (16 << c) + 10, 1);
         chk(channel_number_field, b[2:0]);
         apb(0, `OFS_RESULT_HIGH, 0, q);
         chk(q, c[1] ? v[11:8] : v[11:4]);
         apb(0, `OFS_RESULT_LOW, 0, q);
         chk(q, c[1] ? v[7:0] : {v[3:0], 4'h0});
         chk(irq, c < 4);
         apb(0, `OFS_IRQ_STATUS, 0, q);
         chk(q, 1);
         repeat (2) @(negedge ref_clk);
         chk(irq, 0);
      end
      apb(1, `OFS_CTRL_FIRST, 8'h20, q);
      repeat (2) @(negedge ref_clk);
      chk(converter_power_on, 0);
      $display("conversion test done");
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // main sequence after five reset cycles
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      test_reset;
      test_pins;
      test_conv;
      wrap_up;
   end
   // watchdog
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors = num_errors + 1;
      wrap_up;
   end
endmodule

// ===== adc_ctrl_map.vh
// Purpose: register map, fields, reset values and timing for the converter
// Assumes: APB byte addresses, one 8-bit register per 32-bit word
// Notes:   included by adc_conversion_control.v
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH
`define OFS_CTRL_FIRST   12'h000
`define OFS_CTRL_SECOND  12'h004
`define OFS_PIN_SELECT   12'h008
`define OFS_RESULT_LOW   12'h00c
`define OFS_RESULT_HIGH  12'h010
`define OFS_IRQ_STATUS   12'h014
`define OFS_IRQ_MASK     12'h018
`define BIT_START        7
`define BIT_BUSY         6
`define BIT_POWER_OFF    5
`define BIT_ALIGN        4
`define BIT_INT_REF      7
`define BIT_BANDGAP_EN   6
`define BIT_REF_SEL      4
`define RST_CTRL_FIRST   8'h60
`define RST_CTRL_SECOND  8'h00
`define RST_PIN_SELECT   8'hff
`define SAMPLE_CYCLES    5'h04
`define TOTAL_CYCLES     5'h10
`endif

// ===== adc_ctrl_monitor.sv
// Purpose: port checker for the converter control
// Assumes: zero-wait APB, outputs follow registers one edge late
// Notes:   bound to the design module
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module adc_ctrl_monitor (
   input wire        ref_clk,
   input wire        reset,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        converter_reset,
   input wire        converter_power_on,
   input wire [2:0]  channel_number_field,
   input wire        external_ref_select,
   input wire [7:0]  analog_channels,
   input wire [7:0]  pull_high_disable,
   input wire [7:0]  direction_override
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // write strobes per register
   wire wr = psel && penable && pwrite;
   wire w0 = wr && paddr == `OFS_CTRL_FIRST;
   wire w4 = wr && paddr == `OFS_CTRL_SECOND;
   wire w8 = wr && paddr == `OFS_PIN_SELECT;
   AST_READY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready pulse wrong");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_PIN_ROUTE: assert property (pull_high_disable == analog_channels
      && direction_override == analog_channels) else $error("pin routing");
   AST_PIN_WRITE: assert property (w8 |-> ##2
      analog_channels == $past(pwdata[7:0], 2)) else $error("pin select");
   AST_POWER: assert property (w0 |-> ##2
      converter_power_on == !$past(pwdata[5], 2)) else $error("power");
   AST_START_HOLD: assert property (w0 && pwdata[7] |-> ##2
      converter_reset) else $error("start not holding reset");
   AST_CHANNEL: assert property (w0 |-> ##2
      channel_number_field == $past(pwdata[2:0], 2)) else $error("channel");
   AST_REF_SEL: assert property (w4 |-> ##2
      external_ref_select == $past(pwdata[4], 2)) else $error("ref select");
   // main scenarios reached
   cover property (w0 && pwdata[7]);
   cover property ($rose(converter_reset));
   cover property (pslverr);
endmodule
bind adc_conversion_control adc_ctrl_monitor mon (.ref_clk, .reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .converter_reset, .converter_power_on, .channel_number_field,
   .external_ref_select, .analog_channels, .pull_high_disable,
   .direction_override);

// ===== analog_core_model.sv
// Purpose: analog core stand-in driving the comparator bit
// Assumes: bench picks the bit level per conversion
// Notes:   toggles while idle so a stale bit never passes
`timescale 1ns/10ps
module analog_core_model (
   input  wire ref_clk,
   input  wire converter_reset,
   input  wire converter_power_on,
   input  wire level,
   output reg  comparator_out
);
   // steady answer only inside a conversion
   always @(posedge ref_clk) begin
      if (converter_reset || !converter_power_on) begin
         comparator_out <= !comparator_out;
      end else begin
         comparator_out <= level;
      end
   end
   initial comparator_out = 1'b0;
endmodule
